// ===== core/reset_control_and_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module reset_control_and_watchdog
    import reset_control_pkg::*;
#(
    parameter int TOUT_BASE = TOUT_BASE_CYCLES,
    parameter int WDOG_BASE = WDOG_BASE_TICKS,
    parameter int BOD_FILTER = BOD_FILTER_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supplyGood,
    input wire logic extResetN,
    input wire logic brownoutLow,
    input wire logic brownoutEnableFuse,
    input wire logic [1:0] clockSelectFuses,
    input wire logic scanResetReg,
    input wire logic comparatorBandgapSelect,
    input wire logic adcEnable,
    input wire logic watchdogClearInstruction,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic internalReset,
    output logic ioReset,
    output logic vectorFetchStart,
    output logic bandgapEnable
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam int TOUT_W = 24;
    localparam int WDOG_W = 24;
    localparam int DIV_W = 6;
    localparam int BOD_W = 8;

    typedef struct packed {
        seq_state_t seqState;
        logic [TOUT_W-1:0] toutCnt;
        logic [BOD_W-1:0] bodCnt;
        logic bodActive;
        logic [DIV_W-1:0] divCnt;
        logic [WDOG_W-1:0] wdogCnt;
        logic wdogPulse;
        logic watchdogEnable;
        logic turnoffEnable;
        logic [2:0] turnoffCnt;
        logic [2:0] prescaleSelect;
        logic [4:0] causeFlags;
        logic internalReset;
        logic vectorFetch;
        logic bandgap;
        logic awHeld;
        logic [3:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic wStrb0;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } state_t;

    state_t q;
    state_t d;
    logic ioHold_q;

    logic asyncSrcN;
    logic anySource;
    logic [TOUT_W-1:0] toutLimit;
    logic [WDOG_W-1:0] wdogLimit;
    logic wdogTick;
    logic doWrite;
    logic [7:0] wByte;

    // Supply, pin and the logic reset act on the I/O reset with no clock at all.
    assign asyncSrcN = rst_n & extResetN & supplyGood;
    assign toutLimit = TOUT_W'(TOUT_BASE) << clockSelectFuses;
    assign wdogLimit = WDOG_W'(WDOG_BASE) << q.prescaleSelect;
    assign wdogTick = (q.divCnt == DIV_W'(WDOG_DIV_CYCLES - 1));
    assign anySource = !supplyGood || !extResetN || q.bodActive || scanResetReg
                       || q.wdogPulse;
    assign doWrite = q.awHeld && q.wHeld && !q.bValid;
    assign wByte = q.wData[7:0];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.vectorFetch = 1'b0;
        d.wdogPulse = 1'b0;
        d.bandgap = brownoutEnableFuse || comparatorBandgapSelect || adcEnable;

        // Brown-out filter: only drops that persist are taken as a reset.
        // brownoutLow is sampled on the clock and must be seen on BOD_FILTER edges in a row,
        // so with BOD_FILTER above 1 a glitch shorter than one cycle never sets bodActive.
        if (brownoutEnableFuse && brownoutLow) begin
            if (q.bodCnt >= BOD_W'(BOD_FILTER - 1)) begin
                d.bodActive = 1'b1;
            end else begin
                d.bodCnt = q.bodCnt + 1'b1;
            end
        end else begin
            d.bodCnt = '0;
            d.bodActive = 1'b0;
        end

        // Reset sequencer.
        case (q.seqState)
            ST_RUN: begin
                if (anySource) begin
                    d.seqState = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!anySource) begin
                    d.seqState = ST_STRETCH;
                    d.toutCnt = '0;
                end
            end
            ST_STRETCH: begin
                if (anySource) begin
                    d.seqState = ST_HOLD;
                end else if (q.toutCnt >= toutLimit - 1'b1) begin
                    d.seqState = ST_RUN;
                    d.vectorFetch = 1'b1;
                end else begin
                    d.toutCnt = q.toutCnt + 1'b1;
                end
            end
            default: begin
                d.seqState = ST_HOLD;
            end
        endcase
        d.internalReset = (d.seqState != ST_RUN);

        // --------------------------------------------------------------
        // Watchdog
        // --------------------------------------------------------------

        // Watchdog oscillator rate as an enable pulse.
        d.divCnt = wdogTick ? '0 : q.divCnt + 1'b1;
        if (q.internalReset || !q.watchdogEnable || watchdogClearInstruction) begin
            d.wdogCnt = '0;
        end else if (wdogTick) begin
            if (q.wdogCnt >= wdogLimit - 1'b1) begin
                d.wdogCnt = '0;
                d.wdogPulse = 1'b1;
            end else begin
                d.wdogCnt = q.wdogCnt + 1'b1;
            end
        end

        // Turn-off window closes by itself.
        if (q.turnoffCnt != 3'h0) begin
            d.turnoffCnt = q.turnoffCnt - 1'b1;
            if (q.turnoffCnt == 3'h1) begin
                d.turnoffEnable = 1'b0;
            end
        end

        // --------------------------------------------------------------
        // Register bus
        // --------------------------------------------------------------

        // AXI4-Lite write channel.
        if (s_axi_awvalid && q.awReady) begin
            d.awHeld = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wReady) begin
            d.wHeld = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb0 = s_axi_wstrb[0];
        end
        if (q.bValid && s_axi_bready) begin
            d.bValid = 1'b0;
        end
        if (doWrite) begin
            d.awHeld = 1'b0;
            d.wHeld = 1'b0;
            d.bValid = 1'b1;
            d.bResp = RESP_OKAY;
            if (q.awAddr == RESET_CAUSE_STATUS_OFS) begin
                if (q.wStrb0) begin
                    d.causeFlags = q.causeFlags & wByte[4:0];
                end
            end else if (q.awAddr == WATCHDOG_CONTROL_OFS) begin
                if (q.wStrb0) begin
                    d.prescaleSelect = wByte[PRESCALE_LSB +: 3];
                    if (wByte[WATCHDOG_ENABLE_BIT]) begin
                        d.watchdogEnable = 1'b1;
                    end else if (q.turnoffEnable) begin
                        d.watchdogEnable = 1'b0;
                    end
                    if (wByte[WATCHDOG_TURNOFF_ENABLE_BIT]) begin
                        d.turnoffEnable = 1'b1;
                        d.turnoffCnt = TURNOFF_WINDOW_CYCLES;
                    end
                end
            end else begin
                d.bResp = RESP_SLVERR;
            end
        end
        d.awReady = !d.awHeld && !d.bValid;
        d.wReady = !d.wHeld && !d.bValid;

        // AXI4-Lite read channel.
        if (q.rValid && s_axi_rready) begin
            d.rValid = 1'b0;
        end
        if (s_axi_arvalid && q.arReady) begin
            d.rValid = 1'b1;
            d.rData = '0;
            d.rResp = RESP_OKAY;
            if (s_axi_araddr == RESET_CAUSE_STATUS_OFS) begin
                d.rData[4:0] = q.causeFlags;
            end else if (s_axi_araddr == WATCHDOG_CONTROL_OFS) begin
                // Upper bits stay zero.
                d.rData[7:0] = {3'h0, q.turnoffEnable, q.watchdogEnable,
                                q.prescaleSelect};
            end else begin
                d.rResp = RESP_SLVERR;
            end
        end
        d.arReady = !d.rValid;

        // Chip reset returns control state to its initial values.
        if (q.internalReset) begin
            d.watchdogEnable = 1'b0;
            d.turnoffEnable = 1'b0;
            d.turnoffCnt = 3'h0;
            d.prescaleSelect = PRESCALE_RESET;
        end

        // --------------------------------------------------------------
        // Reset cause flags
        // --------------------------------------------------------------

        // Hardware sets are applied last so they win over a software clear.
        if (!supplyGood) begin
            // Supply-on reset clears every other cause.
            d.causeFlags = '0;
            d.causeFlags[SUPPLY_ON_RESET_FLAG_BIT] = 1'b1;
        end else begin
            if (scanResetReg) begin
                d.causeFlags[SCAN_RESET_FLAG_BIT] = 1'b1;
            end
            if (q.wdogPulse) begin
                d.causeFlags[WATCHDOG_RESET_FLAG_BIT] = 1'b1;
            end
            if (q.bodActive) begin
                d.causeFlags[BROWNOUT_RESET_FLAG_BIT] = 1'b1;
            end
            if (!extResetN) begin
                d.causeFlags[PIN_RESET_FLAG_BIT] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.seqState <= ST_HOLD;
            q.internalReset <= 1'b1;
            q.causeFlags <= CAUSE_RESET;
            q.prescaleSelect <= PRESCALE_RESET;
        end else begin
            q <= d;
        end
    end

    // The I/O reset must act before any clock edge, so it has its own
    // asynchronously set flop and only its release waits for the clock.
    always_ff @(posedge sys_clk or negedge asyncSrcN) begin
        if (!asyncSrcN) begin
            ioHold_q <= 1'b1;
        end else begin
            ioHold_q <= d.internalReset;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    assign s_axi_awready = q.awReady;
    assign s_axi_wready = q.wReady;
    assign s_axi_bvalid = q.bValid;
    assign s_axi_bresp = q.bResp;
    assign s_axi_arready = q.arReady;
    assign s_axi_rvalid = q.rValid;
    assign s_axi_rdata = q.rData;
    assign s_axi_rresp = q.rResp;
    assign internalReset = q.internalReset;
    assign ioReset = ioHold_q;
    assign vectorFetchStart = q.vectorFetch;
    assign bandgapEnable = q.bandgap;

endmodule
`default_nettype wire

// ===== core/reset_control_pkg.sv
package reset_control_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] RESET_CAUSE_STATUS_OFS = 4'h0;
    localparam logic [3:0] WATCHDOG_CONTROL_OFS = 4'h4;

    // Reset-cause flag positions.
    localparam int SUPPLY_ON_RESET_FLAG_BIT = 0;
    localparam int PIN_RESET_FLAG_BIT = 1;
    localparam int BROWNOUT_RESET_FLAG_BIT = 2;
    localparam int WATCHDOG_RESET_FLAG_BIT = 3;
    localparam int SCAN_RESET_FLAG_BIT = 4;

    // Watchdog control field positions.
    localparam int WATCHDOG_TURNOFF_ENABLE_BIT = 4;
    localparam int WATCHDOG_ENABLE_BIT = 3;
    localparam int PRESCALE_LSB = 0;

    localparam logic [4:0] CAUSE_RESET = 5'h00;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int WDOG_OSC_HZ = 1_000_000;
    localparam int WDOG_DIV_CYCLES = SYS_CLK_HZ / WDOG_OSC_HZ;
    localparam logic [2:0] TURNOFF_WINDOW_CYCLES = 3'h4;
    localparam int WDOG_BASE_TICKS = 16_384;
    localparam int TOUT_BASE_CYCLES = 1_024;
    localparam int BOD_FILTER_CYCLES = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_HOLD = 3'b010,
        ST_STRETCH = 3'b100
    } seq_state_t;

endpackage

// ===== verif/reset_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Port checks
// ------------------------------------------------------------------
module reset_control_chk
    import reset_control_pkg::*;
#(
    parameter int TOUT_BASE = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supplyGood,
    input wire logic extResetN,
    input wire logic brownoutLow,
    input wire logic brownoutEnableFuse,
    input wire logic [1:0] clockSelectFuses,
    input wire logic scanResetReg,
    input wire logic comparatorBandgapSelect,
    input wire logic adcEnable,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic internalReset,
    input wire logic ioReset,
    input wire logic vectorFetchStart,
    input wire logic bandgapEnable
);
    wire logic srcOn = !supplyGood || !extResetN || scanResetReg;
    wire logic bodOn = brownoutLow && brownoutEnableFuse;
    logic [15:0] quietCnt_q;
    // Counts quiet cycles; a release earlier than the stretch after a pin, supply, scan or brown-out reset would show here.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            quietCnt_q <= 16'h0000;
        end else if (srcOn || bodOn) begin
            quietCnt_q <= 16'h0000;
        end else if (quietCnt_q != 16'hffff) begin
            quietCnt_q <= quietCnt_q + 16'h0001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_fetchOnce;
        vectorFetchStart ##1 !vectorFetchStart;
    endsequence
    property p_pinIo; !extResetN |-> ioReset; endproperty
    a_pinIo: assert property (p_pinIo)
        else $error("io reset missing while pin low");
    property p_supplyIo; !supplyGood |-> ioReset ##1 internalReset; endproperty
    a_supplyIo: assert property (p_supplyIo)
        else $error("supply low did not reset");
    property p_scanHold; scanResetReg |-> ##[1:2] internalReset; endproperty
    a_scanHold: assert property (p_scanHold)
        else $error("scan reset not held");
    property p_ioFollow; internalReset |-> ioReset; endproperty
    a_ioFollow: assert property (p_ioFollow)
        else $error("io reset below internal reset");
    property p_fetch; $fell(internalReset) |-> s_fetchOnce; endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch start pulse wrong");
    property p_stretch; $fell(internalReset) |-> quietCnt_q >= (TOUT_BASE << clockSelectFuses);
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("reset released before time-out");
    property p_bandgap;
        1'b1 |=> bandgapEnable == $past(brownoutEnableFuse | comparatorBandgapSelect | adcEnable);
    endproperty
    a_bandgap: assert property (p_bandgap)
        else $error("bandgap enable wrong");
    property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bHold: assert property (p_bHold)
        else $error("write response dropped");
    property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rHold: assert property (p_rHold)
        else $error("read data dropped");
endmodule
bind reset_control_and_watchdog reset_control_chk #(.TOUT_BASE(TOUT_BASE)) i_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .supplyGood(supplyGood), .extResetN(extResetN),
    .brownoutLow(brownoutLow), .brownoutEnableFuse(brownoutEnableFuse),
    .clockSelectFuses(clockSelectFuses), .scanResetReg(scanResetReg),
    .comparatorBandgapSelect(comparatorBandgapSelect), .adcEnable(adcEnable),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .internalReset(internalReset), .ioReset(ioReset), .vectorFetchStart(vectorFetchStart),
    .bandgapEnable(bandgapEnable)
);
`default_nettype wire

// ===== verif/reset_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Reset sources seen from outside the block
// ------------------------------------------------------------------
module reset_source_model (
    input wire logic sys_clk,
    input wire logic kick,
    input wire logic [1:0] src,
    input wire logic [7:0] len,
    output wire logic supplyGood,
    output wire logic extResetN,
    output wire logic brownoutLow,
    output wire logic scanResetReg
);
    // Supply starts below threshold, so the run opens with a supply-on event.
    logic [7:0] left = 8'h10;
    logic [1:0] which = 2'h3;
    wire logic on = (left != 8'h00);
    always @(posedge sys_clk) begin
        if (kick) begin
            left <= len;
            which <= src;
        end else if (on) begin
            left <= left - 8'h01;
        end
    end
    assign extResetN = !(on && which == 2'h0);
    assign scanResetReg = on && which == 2'h1;
    assign brownoutLow = on && which == 2'h2;
    assign supplyGood = !(on && which == 2'h3);
endmodule
`default_nettype wire

// ===== verif/test_reset_control_and_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
// ------------------------------------------------------------------
// Register and reset sequence tests
// ------------------------------------------------------------------
module test_reset_control_and_watchdog import reset_control_pkg::*;;
    logic sys_clk = 0, rst_n = 0, kick = 0, adcEnable = 0, comparatorBandgapSelect = 0;
    logic brownoutEnableFuse = 0, watchdogClearInstruction = 0;
    logic [1:0] src = 0, clockSelectFuses = 0, r, s_axi_bresp, s_axi_rresp;
    logic [7:0] len = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    // Response readies stay high, so back-to-back calls never drive them twice in a step.
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
    logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, supplyGood, extResetN, brownoutLow, scanResetReg;
    logic internalReset, ioReset, vectorFetchStart, bandgapEnable;
    int err_count = 0, compares = 0, cyc = 0, n, ex;
    logic [7:0] lens [4] = '{8'h04, 8'h14, 8'h06, 8'h04};
    logic [7:0] exps [4] = '{8'h02, 8'h10, 8'h04, 8'h01};
    reset_source_model i_src (.sys_clk(sys_clk), .kick(kick), .src(src), .len(len),
        .supplyGood(supplyGood), .extResetN(extResetN), .brownoutLow(brownoutLow),
        .scanResetReg(scanResetReg));
    reset_control_and_watchdog #(.TOUT_BASE(4), .WDOG_BASE(4), .BOD_FILTER(2)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .supplyGood(supplyGood), .extResetN(extResetN),
        .brownoutLow(brownoutLow), .brownoutEnableFuse(brownoutEnableFuse),
        .clockSelectFuses(clockSelectFuses), .scanResetReg(scanResetReg),
        .comparatorBandgapSelect(comparatorBandgapSelect), .adcEnable(adcEnable),
        .watchdogClearInstruction(watchdogClearInstruction), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .internalReset(internalReset),
        .ioReset(ioReset), .vectorFetchStart(vectorFetchStart), .bandgapEnable(bandgapEnable));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // The timeout is the only thing that ends a bus wait that gets no response.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                rs = s_axi_bresp;
                break;
            end
        end
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                v = s_axi_rdata;
                rs = s_axi_rresp;
                break;
            end
        end
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
        rd(a, d, r);
        `CHK("register", e, d)
    endtask
    task automatic wait_rel();
        for (n = 0; n < 3000 && internalReset !== 1'b0; n++) @(posedge sys_clk);
        `CHK("released", 1'b0, internalReset)
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        wait_rel();
        chk_rd(RESET_CAUSE_STATUS_OFS, 32'h01);
        s_axi_wstrb <= 4'h0;
        wr(RESET_CAUSE_STATUS_OFS, 32'h00, r);
        s_axi_wstrb <= 4'hf;
        `CHK("masked write resp", RESP_OKAY, r)
        chk_rd(RESET_CAUSE_STATUS_OFS, 32'h01);
        chk_rd(WATCHDOG_CONTROL_OFS, 32'h00);
        wr(WATCHDOG_CONTROL_OFS, 32'he8, r);
        chk_rd(WATCHDOG_CONTROL_OFS, 32'h08);
        wr(WATCHDOG_CONTROL_OFS, 32'h00, r);
        chk_rd(WATCHDOG_CONTROL_OFS, 32'h08);
        wr(WATCHDOG_CONTROL_OFS, 32'h18, r);
        repeat (8) @(posedge sys_clk);
        chk_rd(WATCHDOG_CONTROL_OFS, 32'h08);
        wr(WATCHDOG_CONTROL_OFS, 32'h18, r);
        wr(WATCHDOG_CONTROL_OFS, 32'h00, r);
        chk_rd(WATCHDOG_CONTROL_OFS, 32'h00);
        rd(4'h8, d, r);
        `CHK("unmapped read", RESP_SLVERR, r)
        wr(4'hc, 32'h00, r);
        `CHK("unmapped write", RESP_SLVERR, r)
        for (int k = 0; k < 8; k++) begin
            {brownoutEnableFuse, comparatorBandgapSelect, adcEnable} <= k[2:0];
            repeat (3) @(posedge sys_clk);
            `CHK("bandgap", |k[2:0], bandgapEnable)
        end
        for (int p = 0; p < 2; p++) begin
            wr(RESET_CAUSE_STATUS_OFS, 32'h00, r);
            wr(WATCHDOG_CONTROL_OFS, 32'h08 | p, r);
            watchdogClearInstruction <= 1'b1;
            repeat (300) @(posedge sys_clk);
            watchdogClearInstruction <= 1'b0;
            ex = (4 << p) * 40;
            for (n = 0; n < 1000 && internalReset !== 1'b1; n++) @(posedge sys_clk);
            `CHK("watchdog period", 1'b1, n + 45 >= ex && n <= ex + 45)
            wait_rel();
            chk_rd(RESET_CAUSE_STATUS_OFS, 32'h08);
        end
        src <= 2'h2;
        len <= 8'h01;
        kick <= 1'b1;
        @(posedge sys_clk);
        kick <= 1'b0;
        repeat (6) @(posedge sys_clk);
        `CHK("short brown-out", 1'b0, internalReset)
        for (int i = 0; i < 4; i++) begin
            clockSelectFuses <= i[1:0];
            if (i < 3) wr(RESET_CAUSE_STATUS_OFS, 32'h00, r);
            src <= i[1:0];
            len <= lens[i];
            kick <= 1'b1;
            @(posedge sys_clk);
            kick <= 1'b0;
            repeat (6) @(posedge sys_clk);
            `CHK("held reset", 1'b1, internalReset)
            wait_rel();
            chk_rd(RESET_CAUSE_STATUS_OFS, {24'h0, exps[i]});
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
